// ==== bank_nvm_consts.vh ====
`ifndef BANK_NVM_CONSTS_VH
`define BANK_NVM_CONSTS_VH
// register addresses in data space
`define ADDR_PAGE_SELECT 8'hcb
`define ADDR_NVM_CONTROL 8'hdf
// banked window 00h-3fh: top two address bits zero
`define WINDOW_TOP_BITS 2'h0
// page select bit positions
`define SEL_RAM_TWO 4
`define SEL_RAM_ONE 3
`define SEL_NVM_ONE 1
`define SEL_NVM_ZERO 0
// control register bit positions
`define CTL_STANDBY 6
`define CTL_ROW_START 3
`define CTL_ROW_MODE 2
`define CTL_ACTIVE 1
`define CTL_WRITE_EN 0
`define CTL_RESET 8'h00
// erased cell value
`define NVM_ERASED 8'hff
`define ZERO_BYTE 8'h00
`define ZERO_ROW 8'h00
// default programming cycle length in clocks
`define PROG_CYCLES_DEFAULT 1000
`endif

// ==== bank_mem.v ====
`timescale 1ns/100ps
// =====================================================
// simple flop page storage, 64 bytes, write on strobe
module bank_mem #(
  parameter DEPTH = 64,
  parameter AW = 6,
  parameter [7:0] INIT = 8'h00
) (
  // clock and reset
  input wire clk_sys,
  input wire srst,
  input wire use_init,
  // write port
  input wire wr,
  input wire [AW-1:0] waddr,
  input wire [7:0] wdata,
  // read port
  input wire [AW-1:0] raddr,
  output wire [7:0] rdata
);
  wire [7:0] cell_w [0:DEPTH-1];
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_cell
      reg [7:0] cell_q;
      always @(posedge clk_sys) begin
        // only nonvolatile pages load their erased value at reset
        if (srst && use_init)
          cell_q <= INIT;
        else if (wr && waddr == i[AW-1:0])
          cell_q <= wdata;
      end
      assign cell_w[i] = cell_q;
    end
  endgenerate
  assign rdata = cell_w[raddr];
endmodule

// ==== row_latch.v ====
`timescale 1ns/100ps
`include "bank_nvm_consts.vh"
// =====================================================
// eight volatile row latches with per-byte written flags
module row_latch #(
  parameter N = 8
) (
  // clock and reset
  input wire clk_sys,
  input wire srst,
  // control
  input wire clear,
  input wire load,
  input wire [2:0] idx,
  input wire [7:0] wdata,
  // state
  output wire [N-1:0] written_q,
  output wire [8*N-1:0] data_flat
);
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_lat
      // each lane owns its flops, so no vector has several drivers
      reg [7:0] byte_q;
      reg flag_q;
      always @(posedge clk_sys) begin
        if (srst || clear) begin
          byte_q <= `ZERO_BYTE;
          flag_q <= 1'b0;
        end else if (load && idx == i[2:0]) begin
          byte_q <= wdata;
          flag_q <= 1'b1;
        end
      end
      assign written_q[i] = flag_q;
      assign data_flat[8*i+7:8*i] = byte_q;
    end
  endgenerate
endmodule

// ==== banked_data_eeprom_control.v ====
`timescale 1ns/100ps
`include "bank_nvm_consts.vh"
// Overview of operation
// R1 - each select bit maps one page
// R2 - codes 00,01,02,08,10h pick none or pages
// R3 - page select at cbh, byte writes only
// R4 - 00h-3fh routed to page, low six bits
// R5 - page select not cleared by reset
// R6 - calls and interrupts leave page select alone
// R7 - software sets at most one page bit
// R8 - standby or no bank makes access meaningless
// R9 - busy during programming; accesses aborted
// R10 - control writes ignored while busy
// R11 - idle nvm reads like ordinary data
// R12 - write enable clear starts no programming
// R13 - byte mode programs addressed byte directly
// R14 - rows of eight bytes, bits 5..3 row
// R15 - row mode clears latches, latches row address
// R16 - other rows erroneous in row mode
// R17 - row start programs only written bytes
// R18 - row cycle end clears start and mode
// R19 - row start needs write enable and mode
// R20 - clearing mode cancels row, no change
// R21 - control at dfh, resets 00h, reserved zero
// R22 - software keeps ram image of write-only regs
// R23 - programming length is a clock-count parameter
module banked_data_eeprom_control #(
  parameter PROG_CYCLES = `PROG_CYCLES_DEFAULT
) (
  // clock and reset
  input wire clk_sys,
  input wire srst,
  // cpu data-space bus
  input wire [7:0] addr,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  output reg rd_hit,
  // status
  output wire access_error,
  output wire nvm_program_active
);
  localparam ST_IDLE = 2'h0;
  localparam ST_BYTE = 2'h1;
  localparam ST_ROW = 2'h2;
  // wide enough for any programming length parameter
  localparam CW = 32;
  localparam PAGE_BYTES = 64;
  localparam [7:0] CTL_RST = `CTL_RESET;

  // =====================================================
  // page select register
  reg [7:0] page_select_reg;
  wire win_hit = addr[7:6] == `WINDOW_TOP_BITS; // R4
  wire [5:0] off = addr[5:0]; // R4
  // no reset branch: content stays undefined until written
  always @(posedge clk_sys) begin // R5 R6
    if (wr_en && addr == `ADDR_PAGE_SELECT)
      page_select_reg <= wdata; // R3
  end
  wire ram_page_two_sel = page_select_reg[`SEL_RAM_TWO]; // R1
  wire ram_page_one_sel = page_select_reg[`SEL_RAM_ONE]; // R1
  wire nvm_page_one_sel = page_select_reg[`SEL_NVM_ONE]; // R1
  wire nvm_page_zero_sel = page_select_reg[`SEL_NVM_ZERO]; // R1
  wire [3:0] sel_vec = {ram_page_two_sel, ram_page_one_sel,
    nvm_page_one_sel, nvm_page_zero_sel};
  // more than one page bit: no page is accessed, flagged as error
  wire multi_sel = (sel_vec & (sel_vec - 4'h1)) != 4'h0; // R7 R2
  wire nvm_sel = nvm_page_zero_sel | nvm_page_one_sel;

  // =====================================================
  // control register
  reg nvm_standby_q;
  reg row_program_start_q;
  reg row_mode_enable_q;
  reg nvm_write_enable_q;
  reg [1:0] state_q;
  reg [CW-1:0] cnt_q;
  reg [2:0] row_q;
  reg row_valid_q;
  reg [5:0] bp_off_q;
  reg [7:0] bp_data_q;
  reg bp_page_q;
  reg row_page_q;
  assign nvm_program_active = state_q != ST_IDLE; // R9
  wire busy = nvm_program_active;
  wire ctl_wr = wr_en && addr == `ADDR_NVM_CONTROL;
  wire nvm_live = win_hit && nvm_sel && !multi_sel && !nvm_standby_q;
  wire nvm_wr = wr_en && nvm_live && !busy; // R8 R9
  wire row_mode_wr = nvm_wr && row_mode_enable_q;
  wire row_ok = !row_valid_q || row_q == off[5:3]; // R16
  wire row_load = row_mode_wr && nvm_write_enable_q && row_ok; // R15
  wire byte_go = nvm_wr && !row_mode_enable_q && nvm_write_enable_q; // R12 R13
  // start counts only if the same write keeps mode and enable set
  wire row_go = ctl_wr && !busy && wdata[`CTL_ROW_START] &&
    wdata[`CTL_WRITE_EN] && wdata[`CTL_ROW_MODE] &&
    row_mode_enable_q; // R19
  wire prog_done = busy && cnt_q == PROG_CYCLES - 1; // R23
  wire mode_rise = ctl_wr && !busy && wdata[`CTL_ROW_MODE] &&
    !row_mode_enable_q; // R15
  wire mode_drop = ctl_wr && !busy && !wdata[`CTL_ROW_MODE]; // R20
  wire [7:0] written;
  wire [63:0] lat_flat;

  always @(posedge clk_sys) begin
    if (srst) begin // R21
      nvm_standby_q <= CTL_RST[`CTL_STANDBY];
      row_program_start_q <= CTL_RST[`CTL_ROW_START];
      row_mode_enable_q <= CTL_RST[`CTL_ROW_MODE];
      nvm_write_enable_q <= CTL_RST[`CTL_WRITE_EN];
      state_q <= ST_IDLE;
      cnt_q <= {CW{1'b0}};
      row_q <= 3'h0;
      row_valid_q <= 1'b0;
      bp_off_q <= 6'h00;
      bp_data_q <= `ZERO_BYTE;
      bp_page_q <= 1'b0;
      row_page_q <= 1'b0;
    end else begin
      if (ctl_wr && !busy) begin // R10
        nvm_standby_q <= wdata[`CTL_STANDBY];
        row_mode_enable_q <= wdata[`CTL_ROW_MODE];
        nvm_write_enable_q <= wdata[`CTL_WRITE_EN];
        row_program_start_q <= row_go; // R19
      end
      if (mode_rise || mode_drop)
        row_valid_q <= 1'b0; // R15 R20
      else if (row_load && !row_valid_q) begin
        row_valid_q <= 1'b1; // R15
        row_q <= off[5:3]; // R14
        row_page_q <= nvm_page_one_sel;
      end
      case (state_q)
        ST_IDLE: begin
          cnt_q <= {CW{1'b0}};
          if (row_go)
            state_q <= ST_ROW; // R17
          else if (byte_go) begin
            state_q <= ST_BYTE; // R13
            bp_off_q <= off;
            bp_data_q <= wdata;
            bp_page_q <= nvm_page_one_sel;
          end
        end
        ST_BYTE, ST_ROW: begin
          cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1}; // R23
          if (prog_done) begin
            state_q <= ST_IDLE;
            if (state_q == ST_ROW) begin
              row_program_start_q <= 1'b0; // R18
              row_mode_enable_q <= 1'b0; // R18
              row_valid_q <= 1'b0;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // =====================================================
  // row latches and storage pages
  row_latch #(.N(8)) u_row (
    .clk_sys(clk_sys),
    .srst(srst),
    .clear(mode_rise || mode_drop), // R15
    .load(row_load),
    .idx(off[2:0]), // R14
    .wdata(wdata),
    .written_q(written),
    .data_flat(lat_flat)
  );

  // cells commit at cycle end: byte mode one cell, row mode the
  // written lanes; no other byte of the page changes
  wire commit_b = prog_done && state_q == ST_BYTE;
  wire commit_r = prog_done && state_q == ST_ROW && row_program_start_q;
  wire [7:0] rd [0:3];
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_page
      wire psel = sel_vec[p];
      reg w;
      reg [5:0] wa;
      reg [7:0] wd;
      always @* begin
        w = 1'b0;
        wa = off;
        wd = wdata;
        if (p < 2) begin
          if (commit_b && bp_page_q == p[0]) begin
            w = 1'b1; // R13
            wa = bp_off_q;
            wd = bp_data_q;
          end
        end else begin
          w = wr_en && win_hit && psel && !multi_sel;
        end
      end
      if (p < 2) begin : g_nvm
        // row commit uses one write port per lane; reset loads the
        // erased state so a fresh array reads as blank
        reg [7:0] cells_q [0:PAGE_BYTES-1];
        integer j;
        always @(posedge clk_sys) begin
          if (srst) begin
            for (j = 0; j < PAGE_BYTES; j = j + 1)
              cells_q[j] <= `NVM_ERASED;
          end else begin
            if (w)
              cells_q[wa] <= wd;
            for (j = 0; j < 8; j = j + 1)
              if (commit_r && row_page_q == p[0] && written[j]) // R17
                cells_q[{row_q, j[2:0]}] <= lat_flat[8*j +: 8];
          end
        end
        assign rd[p] = cells_q[off];
      end else begin : g_ram
        bank_mem #(.DEPTH(64), .AW(6), .INIT(`ZERO_BYTE)) u_mem (
          .clk_sys(clk_sys),
          .srst(srst),
          .use_init(1'b0),
          .wr(w),
          .waddr(wa),
          .wdata(wd),
          .raddr(off),
          .rdata(rd[p])
        );
      end
    end
  endgenerate

  // =====================================================
  // page decode: only a single select bit opens a page; any
  // other pattern is reserved and reads back nothing
  localparam [3:0] PG_NVM_ZERO = 4'h1;
  localparam [3:0] PG_NVM_ONE = 4'h2;
  localparam [3:0] PG_RAM_ONE = 4'h4;
  localparam [3:0] PG_RAM_TWO = 4'h8;
  reg [7:0] page_rdata;
  reg page_hit;
  always @* begin
    page_rdata = `ZERO_BYTE;
    page_hit = 1'b0;
    case (sel_vec)
      PG_NVM_ZERO: begin
        page_hit = 1'b1; // R2
        page_rdata = rd[0]; // R11
      end
      PG_NVM_ONE: begin
        page_hit = 1'b1; // R2
        page_rdata = rd[1]; // R11
      end
      PG_RAM_ONE: begin
        page_hit = 1'b1; // R2
        page_rdata = rd[2];
      end
      PG_RAM_TWO: begin
        page_hit = 1'b1; // R2
        page_rdata = rd[3];
      end
      default: begin
        page_hit = 1'b0;
        page_rdata = `ZERO_BYTE;
      end
    endcase
  end

  // =====================================================
  // read path and error report
  // a page that cannot be read safely shows the erased value, so
  // software never sees a half-programmed cell
  wire nvm_rd_bad = nvm_sel && (nvm_standby_q || busy ||
    row_mode_enable_q); // R8 R9 R16
  wire nvm_off_err = nvm_sel && (nvm_standby_q || busy); // R8 R9
  wire row_err = nvm_sel && row_mode_enable_q && !row_ok; // R16
  assign access_error = win_hit && (rd_en || wr_en) &&
    (multi_sel || nvm_off_err || row_err); // R7

  always @(posedge clk_sys) begin
    if (srst) begin
      rdata <= `ZERO_BYTE;
      rd_hit <= 1'b0;
    end else begin
      rd_hit <= 1'b0;
      if (rd_en && addr == `ADDR_NVM_CONTROL) begin
        // write-only bits read as zero
        rdata <= {6'h00, busy, 1'b0}; // R9 R21
        rd_hit <= 1'b1;
      end else if (rd_en && win_hit && page_hit) begin // R2
        rd_hit <= 1'b1;
        if (nvm_rd_bad)
          rdata <= `NVM_ERASED;
        else
          rdata <= page_rdata; // R11
      end
    end
  end
endmodule

// ==== bdec_checker.sv ====
`timescale 1ns/100ps
// ====
// port-level checks
module bdec_checker #(
  parameter PROG_CYCLES = 8
) (
  // clock and reset
  input wire clk_sys,
  input wire srst,
  // cpu bus
  input wire [7:0] addr,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] wdata,
  input wire [7:0] rdata,
  input wire rd_hit,
  // status
  input wire access_error,
  input wire nvm_program_active
);
  reg [15:0] cnt_q;
  wire busy = nvm_program_active;
  // counts busy cycles so the length is checked without long repeats
  always @(posedge clk_sys) begin
    if (srst || !busy) cnt_q <= 16'h0;
    else cnt_q <= cnt_q + 16'h1;
  end
  // page select cannot be read back, so keep a copy of it here
  reg [7:0] sel_q;
  always @(posedge clk_sys) begin
    if (wr_en && addr == 8'hcb) sel_q <= wdata;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_ctl_rd; rd_en && addr == 8'hdf; endsequence
  sequence s_ctl_wr; wr_en && addr == 8'hdf; endsequence
  a_busy_len: assert property ($fell(busy) |-> cnt_q == PROG_CYCLES)
    else $error("busy length wrong");
  a_ctl_read: assert property (s_ctl_rd |=>
    rd_hit && rdata == {6'h0, $past(busy), 1'b0}) else $error("ctl read");
  a_rst_clear: assert property ($fell(srst) |-> !busy && !rd_hit)
    else $error("reset state");
  a_ps_unread: assert property (rd_en && addr == 8'hcb |=> !rd_hit)
    else $error("select readable");
  a_busy_cause: assert property ($rose(busy) |-> $past(wr_en))
    else $error("busy without write");
  a_hit_cause: assert property (rd_hit |-> $past(rd_en))
    else $error("hit without read");
  sequence s_nvm_acc; (rd_en || wr_en) && addr[7:6] == 2'h0 &&
    (sel_q == 8'h01 || sel_q == 8'h02); endsequence
  a_busy_err: assert property (s_nvm_acc ##0 busy |-> access_error)
    else $error("busy access not flagged");
  a_busy_hold: assert property (s_ctl_wr ##0
    (busy && cnt_q < PROG_CYCLES - 1) |=> busy) else $error("busy cut");
endmodule
bind banked_data_eeprom_control bdec_checker #(
  .PROG_CYCLES(PROG_CYCLES)
) u_chk (
  .clk_sys(clk_sys),
  .srst(srst),
  .addr(addr),
  .wr_en(wr_en),
  .rd_en(rd_en),
  .wdata(wdata),
  .rdata(rdata),
  .rd_hit(rd_hit),
  .access_error(access_error),
  .nvm_program_active(nvm_program_active)
);

// ==== cpu_bus_model.sv ====
`timescale 1ns/100ps
// ====
// cpu core side: one byte access per call
module cpu_bus_model (
  input wire clk_sys,
  output reg [7:0] addr,
  output reg wr_en,
  output reg rd_en,
  output reg [7:0] wdata,
  input wire [7:0] rdata,
  input wire rd_hit
);
  initial begin
    addr = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wdata = 8'h00;
  end
  // byte writes only, never single-bit
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk_sys);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge clk_sys);
      wr_en = 1'b0;
      // released data must not look valid
      wdata = ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d, output h);
    begin
      @(negedge clk_sys);
      addr = a;
      rd_en = 1'b1;
      @(negedge clk_sys);
      rd_en = 1'b0;
      h = rd_hit;
      d = rdata;
    end
  endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
  failures++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb;
  reg clk_sys;
  reg srst;
  wire [7:0] addr;
  wire wr_en;
  wire rd_en;
  wire [7:0] wdata;
  wire [7:0] rdata;
  wire rd_hit;
  wire access_error;
  wire busy;
  integer failures = 0;
  integer cmp_count = 0;
  reg [7:0] d;
  reg h;
  integer err_cnt = 0;
  integer e0;
  banked_data_eeprom_control #(.PROG_CYCLES(8))
    i_banked_data_eeprom_control (.clk_sys(clk_sys), .srst(srst),
    .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata),
    .rdata(rdata), .rd_hit(rd_hit), .access_error(access_error),
    .nvm_program_active(busy));
  cpu_bus_model i_cpu_bus_model (.clk_sys(clk_sys), .addr(addr),
    .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata),
    .rd_hit(rd_hit));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (access_error === 1'b1) err_cnt <= err_cnt + 1;
  end
  // ====
  // helpers
  // no interrupt context here, so no ram image of write-only regs
  task wr(input [7:0] a, input [7:0] v);
    i_cpu_bus_model.wr(a, v);
  endtask
  task rchk(input [7:0] a, input [7:0] e);
    begin
      i_cpu_bus_model.rd(a, d, h);
      `CHK("hit", 1'b1, h)
      `CHK("rdata", e, d)
    end
  endtask
  task wait_idle;
    integer i;
    begin
      for (i = 0; i < 40 && busy === 1'b1; i++) @(negedge clk_sys);
      `CHK("idle", 1'b0, busy)
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // ====
  // scenarios
  task t_pages;
    begin
      rchk(8'hdf, 8'h00);
      wr(8'hcb, 8'h08);
      wr(8'h05, 8'h11);
      wr(8'h3f, 8'h33);
      wr(8'hcb, 8'h10);
      wr(8'h05, 8'h22);
      rchk(8'h05, 8'h22);
      wr(8'hcb, 8'h08);
      rchk(8'h05, 8'h11);
      rchk(8'h3f, 8'h33);
      i_cpu_bus_model.rd(8'hcb, d, h);
      `CHK("sel hit", 1'b0, h)
    end
  endtask
  task t_byte;
    begin
      wr(8'hdf, 8'h00);
      wr(8'hcb, 8'h01);
      wr(8'h06, 8'h55);
      @(negedge clk_sys);
      `CHK("busy", 1'b0, busy)
      rchk(8'h06, 8'hff);
      wr(8'hdf, 8'h01);
      wr(8'h05, 8'haa);
      @(negedge clk_sys);
      `CHK("busy", 1'b1, busy)
      rchk(8'hdf, 8'h02);
      wr(8'hdf, 8'h40);
      rchk(8'h05, 8'hff);
      wait_idle;
      rchk(8'h05, 8'haa);
      wr(8'hcb, 8'h02);
      rchk(8'h05, 8'hff);
      wr(8'hcb, 8'h01);
    end
  endtask
  task t_row;
    begin
      wr(8'hdf, 8'h05);
      wr(8'h18, 8'h01);
      wr(8'h1a, 8'h02);
      e0 = err_cnt;
      wr(8'h20, 8'h03);
      `CHK("err", e0 + 1, err_cnt)
      wr(8'hdf, 8'h0d);
      @(negedge clk_sys);
      `CHK("busy", 1'b1, busy)
      wait_idle;
      rchk(8'h18, 8'h01);
      rchk(8'h1a, 8'h02);
      rchk(8'h19, 8'hff);
      rchk(8'h20, 8'hff);
      wr(8'hdf, 8'h09);
      @(negedge clk_sys);
      `CHK("busy", 1'b0, busy)
      wr(8'hdf, 8'h05);
      wr(8'h10, 8'h07);
      wr(8'hdf, 8'h01);
      wr(8'hdf, 8'h09);
      @(negedge clk_sys);
      `CHK("busy", 1'b0, busy)
      rchk(8'h10, 8'hff);
    end
  endtask
  task t_standby;
    begin
      wr(8'hdf, 8'h41);
      wr(8'h07, 8'h5a);
      @(negedge clk_sys);
      `CHK("busy", 1'b0, busy)
      wr(8'hdf, 8'h01);
      rchk(8'h07, 8'hff);
    end
  endtask
  initial begin
    srst = 1'b1;
    repeat (12) @(negedge clk_sys);
    srst = 1'b0;
    t_pages;
    t_byte;
    t_row;
    t_standby;
    tally_and_finish;
  end
  // run needs well under 1000 cycles
  initial begin
    #20000;
    failures++;
    tally_and_finish;
  end
endmodule
